// ### rtl/dmadst_pkg.sv
// Package: constants, register map and types of the destination set block
package dmadst_pkg;

  // ==========================================================
  // Sizes
  localparam int DEPTH = 4;          // Number of destination sets
  localparam int IDX_W = 2;          // Bits to index a set
  localparam int ADDR_W = 12;        // Register bus address width
  localparam logic [15:0] CHUNK = 16'h0010; // Most bytes per write command

  // ==========================================================
  // Register map: set n at byte n * 32 (n << SET_SHIFT), word index in set
  localparam int SET_SHIFT = 5;
  localparam logic [2:0] REG_COUNTS = 3'h0;
  localparam logic [2:0] REG_WADDR = 3'h1;
  localparam logic [2:0] REG_INDEX = 3'h2;
  localparam logic [2:0] REG_PROT = 3'h3;
  localparam logic [2:0] REG_RELOAD = 3'h4;
  localparam logic [2:0] REG_SRCREF = 3'h5;
  localparam logic [2:0] REG_DSTREF = 3'h6;

  // ==========================================================
  // Field positions and reset values
  localparam int ARRAYS_LSB = 16;
  localparam int BYTES_LSB = 0;
  localparam int STRIDE_LSB = 16;
  localparam int RANK_BIT = 8;
  localparam int TAG_LSB = 0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [3:0] RST_TAG = 4'h0;
  localparam logic [3:0] TAG_CORE = 4'h1;  // Processor core set the entry
  localparam logic [3:0] TAG_OTHER = 4'h0; // Any other master

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ISSUE = 2'b10
  } dmadst_state_t;

  typedef struct packed {
    logic [31:0] dst_addr;
    logic [15:0] arrays;
    logic [15:0] bytes;
    logic [15:0] stride;
    logic rank;
    logic [3:0] tag;
  } dmadst_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] bytes;
    logic rank;
    logic [3:0] tag;
    logic [IDX_W-1:0] slot;
  } dmadst_cmd_t;

endpackage

// ### rtl/dmadst_top.sv
// Destination set tracking: per-request write state and AXI4-Lite view
// Notes on behaviour
// - One register set per outstanding request slot
// - Upper count half holds arrays left
// - Lower count half holds bytes left
// - Finished set keeps last write address
// - Index upper half signed stride, lower zero
// - Capture privilege level bit on submission
// - Privilege level goes with every command
// - Capture four-bit originator tag on submission
// - Originator tag goes with every command
// - Tag one for core, zero otherwise
// - Reload field restores byte count per array
// - Source reference field always reads zero
// - Dest reference holds current array start
`timescale 1ns/1ps
module dmadst_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request submission from the channel controller
  input wire logic req_valid,
  input wire dmadst_pkg::dmadst_req_t req,
  output logic req_ready,
  // Write commands toward target endpoints
  output logic cmd_valid,
  output dmadst_pkg::dmadst_cmd_t cmd,
  input wire logic cmd_ready,
  // Request completion
  output logic done_valid,
  output logic [dmadst_pkg::IDX_W-1:0] done_slot,
  // AXI4-Lite write channels
  input wire logic [dmadst_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [dmadst_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int D = dmadst_pkg::DEPTH;
  localparam int W = dmadst_pkg::IDX_W;

  // ==========================================================
  // Storage of the sets
  logic [15:0] arrays_left [D];
  logic [15:0] bytes_left_in_array [D];
  logic [31:0] write_pointer [D];
  logic [15:0] dest_array_stride [D];
  logic access_rank_bit [D];
  logic [3:0] originator_tag [D];
  logic [15:0] byte_count_restore [D];
  logic [31:0] dest_ref_field [D];

  dmadst_pkg::dmadst_state_t state_reg;
  logic [W-1:0] alloc_ptr_reg;
  logic [W-1:0] active_ptr_reg;
  logic [W:0] used_reg;
  logic req_ready_reg;
  logic cmd_valid_reg;
  dmadst_pkg::dmadst_cmd_t cmd_reg;
  logic done_valid_reg;
  logic [W-1:0] done_slot_reg;

  logic take_req;
  logic take_cmd;
  logic finish;
  logic empty_job;
  logic last_chunk;
  logic [15:0] chunk_bytes;
  logic [W:0] used_next;

  // Handshakes and queue occupancy
  assign take_req = req_valid && req_ready_reg;
  assign take_cmd = (state_reg == dmadst_pkg::ST_ISSUE) && cmd_ready;
  assign empty_job = (arrays_left[active_ptr_reg] == 16'h0000)
    || (bytes_left_in_array[active_ptr_reg] == 16'h0000);
  assign last_chunk = take_cmd
    && (bytes_left_in_array[active_ptr_reg] == cmd_reg.bytes)
    && (arrays_left[active_ptr_reg] == 16'h0001);
  assign finish = last_chunk || ((state_reg == dmadst_pkg::ST_IDLE)
    && (used_reg != '0) && empty_job);
  assign chunk_bytes = (bytes_left_in_array[active_ptr_reg]
    < dmadst_pkg::CHUNK) ? bytes_left_in_array[active_ptr_reg]
    : dmadst_pkg::CHUNK;
  assign used_next = used_reg + (W+1)'(take_req) - (W+1)'(finish);

  // ==========================================================
  // Per-set capture and progress
  for (genvar i = 0; i < D; i++)
  begin : g_set
    logic upd;
    assign upd = take_cmd && (active_ptr_reg == W'(i));

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        arrays_left[i] <= dmadst_pkg::RST_HALF;
        bytes_left_in_array[i] <= dmadst_pkg::RST_HALF;
        write_pointer[i] <= dmadst_pkg::RST_WORD;
        dest_array_stride[i] <= dmadst_pkg::RST_HALF;
        access_rank_bit[i] <= 1'b0;
        originator_tag[i] <= dmadst_pkg::RST_TAG;
        byte_count_restore[i] <= dmadst_pkg::RST_HALF;
        dest_ref_field[i] <= dmadst_pkg::RST_WORD;
      end
      else if (take_req && (alloc_ptr_reg == W'(i)))
      begin
        arrays_left[i] <= req.arrays;
        bytes_left_in_array[i] <= req.bytes;
        byte_count_restore[i] <= req.bytes;
        write_pointer[i] <= req.dst_addr;
        dest_ref_field[i] <= req.dst_addr;
        dest_array_stride[i] <= req.stride;
        access_rank_bit[i] <= req.rank;
        originator_tag[i] <= req.tag;
      end
      else if (upd)
      begin
        if (bytes_left_in_array[i] != cmd_reg.bytes)
        begin
          // Still inside the array
          bytes_left_in_array[i] <= bytes_left_in_array[i] - cmd_reg.bytes;
          write_pointer[i] <= write_pointer[i] + 32'(cmd_reg.bytes);
        end
        else if (arrays_left[i] == 16'h0001)
        begin
          // Whole request done; pointer keeps last command
          arrays_left[i] <= 16'h0000;
          bytes_left_in_array[i] <= 16'h0000;
        end
        else
        begin
          // Next array: reload bytes, advance start by stride
          arrays_left[i] <= arrays_left[i] - 16'h0001;
          bytes_left_in_array[i] <= byte_count_restore[i];
          dest_ref_field[i] <= dest_ref_field[i]
            + {{16{dest_array_stride[i][15]}}, dest_array_stride[i]};
          write_pointer[i] <= dest_ref_field[i]
            + {{16{dest_array_stride[i][15]}}, dest_array_stride[i]};
        end
      end
    end
  end

  // ==========================================================
  // Slot queue pointers and submission ready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alloc_ptr_reg <= '0;
      active_ptr_reg <= '0;
      used_reg <= '0;
      req_ready_reg <= 1'b0;
    end
    else
    begin
      if (take_req)
        alloc_ptr_reg <= alloc_ptr_reg + W'(1);
      if (finish)
        active_ptr_reg <= active_ptr_reg + W'(1);
      used_reg <= used_next;
      req_ready_reg <= (used_next < (W+1)'(D));
    end
  end

  // ==========================================================
  // Write command engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= dmadst_pkg::ST_IDLE;
      cmd_valid_reg <= 1'b0;
      cmd_reg <= '0;
    end
    else
    begin
      case (state_reg)
        dmadst_pkg::ST_IDLE:
        begin
          if ((used_reg != '0) && !empty_job)
          begin
            cmd_reg.addr <= write_pointer[active_ptr_reg];
            cmd_reg.bytes <= chunk_bytes;
            cmd_reg.rank <= access_rank_bit[active_ptr_reg];
            cmd_reg.tag <= originator_tag[active_ptr_reg];
            cmd_reg.slot <= active_ptr_reg;
            cmd_valid_reg <= 1'b1;
            state_reg <= dmadst_pkg::ST_ISSUE;
          end
        end
        dmadst_pkg::ST_ISSUE:
        begin
          if (cmd_ready)
          begin
            cmd_valid_reg <= 1'b0;
            state_reg <= dmadst_pkg::ST_IDLE;
          end
        end
        default:
        begin
          cmd_valid_reg <= 1'b0;
          state_reg <= dmadst_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Completion pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_valid_reg <= 1'b0;
      done_slot_reg <= '0;
    end
    else
    begin
      done_valid_reg <= finish;
      if (finish)
        done_slot_reg <= active_ptr_reg;
    end
  end

  // ==========================================================
  // AXI4-Lite write side: accepted, stored nowhere
  logic awready_reg;
  logic wready_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [dmadst_pkg::ADDR_W-1:0] aw_addr_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic aw_have;
  logic w_have;
  logic [dmadst_pkg::ADDR_W-1:0] aw_addr_use;

  assign aw_have = aw_held_reg || (s_axi_awvalid && awready_reg);
  assign w_have = w_held_reg || (s_axi_wvalid && wready_reg);
  assign aw_addr_use = aw_held_reg ? aw_addr_reg : s_axi_awaddr;

  // Address and data in either order, then one response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= dmadst_pkg::RESP_OKAY;
    end
    else if (bvalid_reg)
    begin
      if (s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
    else if (aw_have && w_have)
    begin
      // Writes change nothing; mapped ones answer OKAY
      bvalid_reg <= 1'b1;
      bresp_reg <= map_hit(aw_addr_use) ? dmadst_pkg::RESP_OKAY
        : dmadst_pkg::RESP_DECERR;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      else if (!aw_held_reg)
        awready_reg <= 1'b1;
      if (s_axi_wvalid && wready_reg)
      begin
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      else if (!w_held_reg)
        wready_reg <= 1'b1;
    end
  end

  // ==========================================================
  // AXI4-Lite read side
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Address decode: set index and word within set
  function automatic logic map_hit(
    input logic [dmadst_pkg::ADDR_W-1:0] a
  );
    logic [2:0] w;
    w = a[dmadst_pkg::SET_SHIFT-1:2];
    map_hit = (a[dmadst_pkg::ADDR_W-1:dmadst_pkg::SET_SHIFT+W] == '0)
      && (w <= dmadst_pkg::REG_DSTREF);
  endfunction

  // Read word assembly; reserved bits stay zero
  function automatic logic [31:0] read_word(
    input logic [dmadst_pkg::ADDR_W-1:0] a
  );
    logic [W-1:0] s;
    logic [31:0] v;
    s = a[dmadst_pkg::SET_SHIFT+:W];
    v = dmadst_pkg::RST_WORD;
    case (a[dmadst_pkg::SET_SHIFT-1:2])
      dmadst_pkg::REG_COUNTS:
      begin
        v[dmadst_pkg::ARRAYS_LSB+:16] = arrays_left[s];
        v[dmadst_pkg::BYTES_LSB+:16] = bytes_left_in_array[s];
      end
      dmadst_pkg::REG_WADDR: v = write_pointer[s];
      dmadst_pkg::REG_INDEX:
        v[dmadst_pkg::STRIDE_LSB+:16] = dest_array_stride[s];
      dmadst_pkg::REG_PROT:
      begin
        v[dmadst_pkg::RANK_BIT] = access_rank_bit[s];
        v[dmadst_pkg::TAG_LSB+:4] = originator_tag[s];
      end
      dmadst_pkg::REG_RELOAD:
        v[15:0] = byte_count_restore[s];
      dmadst_pkg::REG_SRCREF: v = dmadst_pkg::RST_WORD;
      dmadst_pkg::REG_DSTREF: v = dest_ref_field[s];
      default: v = dmadst_pkg::RST_WORD;
    endcase
    read_word = v;
  endfunction

  // One read at a time, answered the cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= dmadst_pkg::RST_WORD;
      rresp_reg <= dmadst_pkg::RESP_OKAY;
    end
    else if (rvalid_reg)
    begin
      if (s_axi_rready)
      begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= map_hit(s_axi_araddr) ? read_word(s_axi_araddr)
        : dmadst_pkg::RST_WORD;
      rresp_reg <= map_hit(s_axi_araddr) ? dmadst_pkg::RESP_OKAY
        : dmadst_pkg::RESP_DECERR;
    end
    else
      arready_reg <= 1'b1;
  end

  // ==========================================================
  // Outputs from flip-flops
  assign req_ready = req_ready_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd = cmd_reg;
  assign done_valid = done_valid_reg;
  assign done_slot = done_slot_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule

// ### dv/dmadst_checker_assertions.sv
// Checker: protocol and tracking properties of the destination sets
`timescale 1ns/1ps
module dmadst_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests, commands, completion
  input wire logic req_valid,
  input wire dmadst_pkg::dmadst_req_t req,
  input wire logic req_ready,
  input wire logic cmd_valid,
  input wire dmadst_pkg::dmadst_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic done_valid,
  input wire logic [dmadst_pkg::IDX_W-1:0] done_slot,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  // ==========================================================
  // Slot pointers and captured protection
  logic [dmadst_pkg::IDX_W-1:0] in_ptr;
  logic [dmadst_pkg::IDX_W-1:0] out_ptr;
  logic rank_q [dmadst_pkg::DEPTH];
  logic [3:0] tag_q [dmadst_pkg::DEPTH];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Follow submissions and finishes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_ptr <= '0;
      out_ptr <= '0;
    end
    else
    begin
      if (req_valid && req_ready)
      begin
        in_ptr <= in_ptr + 1'b1;
        rank_q[in_ptr] <= req.rank;
        tag_q[in_ptr] <= req.tag;
      end
      if (done_valid)
        out_ptr <= out_ptr + 1'b1;
    end
  end

  // ==========================================================
  // Properties
  a_cmd_held:
    assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd))
    else $error("command changed while stalled");
  a_cmd_gap:
    assert property (cmd_valid && cmd_ready |=> !cmd_valid)
    else $error("no idle cycle after command");
  a_chunk_size:
    assert property (cmd_valid |-> cmd.bytes != 16'h0000 &&
      cmd.bytes <= dmadst_pkg::CHUNK)
    else $error("command size out of range");
  a_cmd_rank:
    assert property (cmd_valid |-> cmd.rank == rank_q[cmd.slot])
    else $error("command rank differs from capture");
  a_cmd_tag:
    assert property (cmd_valid |-> cmd.tag == tag_q[cmd.slot])
    else $error("command tag differs from capture");
  a_done_order:
    assert property (done_valid |-> done_slot == out_ptr)
    else $error("slot finished out of order");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_held:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped while stalled");
  a_bresp_held:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped while stalled");
  a_reset_idle:
    assert property ($rose(aresetn) |-> !cmd_valid && !req_ready &&
      !s_axi_rvalid && !s_axi_bvalid)
    else $error("outputs busy right after reset");
endmodule

bind dmadst_top dmadst_checker u_chk (.*);

// ### dv/dmadst_endpoint.sv
// Endpoint model: accepts write commands with random stalls
`timescale 1ns/1ps
module dmadst_endpoint (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Stall mode
  input wire logic slow,
  // Command acceptance
  output logic cmd_ready
);
  // Fresh ready draw each cycle, rare when slow
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmd_ready <= 1'b0;
    else
      cmd_ready <= slow ? ($urandom % 4 == 0) : ($urandom % 4 != 0);
  end
endmodule

// ### dv/dmadst_top_bench.sv
// Bench: requests, register reads and command stream checks
`timescale 1ns/1ps
module dmadst_top_bench;
  logic aclk, aresetn, req_valid, req_ready, cmd_valid, cmd_ready;
  logic done_valid, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [dmadst_pkg::IDX_W-1:0] done_slot, nslot, done_q[$];
  dmadst_pkg::dmadst_req_t req;
  dmadst_pkg::dmadst_cmd_t cmd, exp_q[$];
  logic [31:0] last_a [4];
  logic [31:0] ref_a [4];
  int failures, checked;

  dmadst_top u_dut (.*);
  dmadst_endpoint u_ep (.*);

  // ==========================================================
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n > 3000)
    begin
      failures++;
      complete_run();
    end
  endtask

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      tmo(n);
    end while (s !== 1'b1);
  endtask

  // ==========================================================
  // Register bus master
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    wait_hi(s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= $urandom;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      tmo(n);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // ==========================================================
  // Requests and expectations
  task automatic submit(input dmadst_pkg::dmadst_req_t r);
    dmadst_pkg::dmadst_cmd_t c;
    logic [31:0] st;
    req <= r;
    req_valid <= 1'b1;
    wait_hi(req_ready);
    req_valid <= 1'b0;
    st = r.dst_addr;
    for (int b = 0; b < r.arrays; b++)
    begin
      for (int o = 0; o < r.bytes; o += 16)
      begin
        c.addr = st + 32'(o);
        c.bytes = (r.bytes - 16'(o) > dmadst_pkg::CHUNK) ?
          dmadst_pkg::CHUNK : r.bytes - 16'(o);
        c.rank = r.rank;
        c.tag = r.tag;
        c.slot = nslot;
        exp_q.push_back(c);
        last_a[nslot] = c.addr;
      end
      // Start of the array last worked on
      ref_a[nslot] = st;
      st = st + {{16{r.stride[15]}}, r.stride};
    end
    done_q.push_back(nslot);
    nslot++;
    @(posedge aclk);
  endtask

  function automatic logic [31:0] reg_exp(dmadst_pkg::dmadst_req_t r,
                                          int k, logic [1:0] s);
    case (k)
      1: return last_a[s];
      2: return {r.stride, 16'h0000};
      3: return {23'h000000, r.rank, 4'h0, r.tag};
      4: return {16'h0000, r.bytes};
      6: return ref_a[s];
      default: return 32'h00000000;
    endcase
  endfunction

  function automatic dmadst_pkg::dmadst_req_t rand_req();
    dmadst_pkg::dmadst_req_t r;
    r.dst_addr = $urandom;
    r.arrays = 16'($urandom_range(3, 1));
    r.bytes = 16'($urandom_range(40, 1));
    r.stride = 16'($urandom);
    r.rank = 1'($urandom);
    r.tag = 4'($urandom);
    return r;
  endfunction

  task automatic drain;
    int n;
    n = 0;
    while (done_q.size() != 0)
    begin
      @(posedge aclk);
      n++;
      tmo(n);
    end
    @(posedge aclk);
  endtask

  task automatic check_set(input dmadst_pkg::dmadst_req_t r,
                           input logic [1:0] s);
    logic [31:0] d;
    logic [1:0] rr;
    for (int k = 0; k < 7; k++)
    begin
      rd({5'h00, s, 3'(k), 2'b00}, d, rr);
      chk(64'(d), 64'(reg_exp(r, k, s)));
    end
  endtask

  // Every taken command and finish pulse in order
  always @(posedge aclk)
  begin
    if (aresetn && cmd_valid && cmd_ready)
      chk(64'(cmd), 64'(exp_q.pop_front()));
    if (aresetn && done_valid)
      chk(64'(done_slot), 64'(done_q.pop_front()));
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] rr;
    logic [1:0] s;
    dmadst_pkg::dmadst_req_t r;
    aresetn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    nslot = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'h037EEDC5));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 33; i++)
    begin
      rd(12'(i * 4), d, rr);
      chk(64'(d), 64'h0);
      chk(64'(rr), (i % 8 == 7 || i == 32) ? 64'h3 : 64'h0);
    end
    $display("test reset values done");
    wr(12'h000, rr);
    chk(64'(rr), 64'(dmadst_pkg::RESP_OKAY));
    wr(12'h01C, rr);
    chk(64'(rr), 64'(dmadst_pkg::RESP_DECERR));
    rd(12'h000, d, rr);
    chk(64'(d), 64'h0);
    $display("test write ignored done");
    r = '{32'h00001000, 16'h0002, 16'h0014, 16'hFFF0, 1'b1,
          dmadst_pkg::TAG_CORE};
    s = nslot;
    submit(r);
    // Counts read before the first command is taken
    rd({5'h00, s, 3'h0, 2'b00}, d, rr);
    chk(64'(d), 64'({r.arrays, r.bytes}));
    drain();
    check_set(r, s);
    $display("test directed walk done");
    for (int i = 0; i < 6; i++)
    begin
      slow <= 1'(i);
      r = rand_req();
      s = nslot;
      submit(r);
      rd({5'h00, s, 3'h0, 2'b00}, d, rr);
      chk(64'(d), 64'({r.arrays, r.bytes}));
      drain();
      check_set(r, s);
    end
    $display("test random requests done");
    slow <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      r = rand_req();
      if (i == 2)
        r.arrays = 16'h0000;
      if (i == 3)
        r.bytes = 16'h0020;
      submit(r);
    end
    drain();
    $display("test full queue done");
    complete_run();
  end
endmodule
